// File: hw/ads_pkg.sv
// package: register map, field positions and states of the transfer status block
package ads_pkg;
    // register byte addresses
    localparam logic [4:0] ADS_CTRL_OFS     = 5'h00;
    localparam logic [4:0] ADS_NCONV_OFS    = 5'h04;
    localparam logic [4:0] ADS_BUFLEN_OFS   = 5'h08;
    localparam logic [4:0] ADS_STATUS_OFS   = 5'h0c;
    localparam logic [4:0] ADS_IRQ_STAT_OFS = 5'h10;
    localparam logic [4:0] ADS_IRQ_CLR_OFS  = 5'h14;
    localparam logic [4:0] ADS_IRQ_EN_OFS   = 5'h18;

    // control register fields
    localparam int ADS_CTRL_DMA_EN_BIT = 0;
    localparam int ADS_CTRL_IU_EN_BIT  = 1;
    localparam int ADS_CTRL_FRAME_BIT  = 2;

    // status register fields
    localparam int ADS_ST_TERM_LSB = 20;
    localparam int ADS_ST_ERR_BIT  = 18;
    localparam int ADS_ST_BSY_BIT  = 17;
    localparam int ADS_ST_IDLE_BIT = 16;
    localparam int ADS_ST_OVF_BIT  = 4;

    // termination cause bits inside the three-bit field
    localparam int ADS_TERM_ABORT = 2;
    localparam int ADS_TERM_BLOCK = 1;
    localparam int ADS_TERM_BEND  = 0;

    // interrupt event bits
    localparam int ADS_IRQ_N        = 3;
    localparam int ADS_IRQ_TERM_BIT = 0;
    localparam int ADS_IRQ_ERR_BIT  = 1;
    localparam int ADS_IRQ_OVF_BIT  = 2;

    // reset values and widths
    localparam int          ADS_CNT_W      = 16;
    localparam logic [2:0]  ADS_CTRL_RST   = 3'h0;
    localparam logic [15:0] ADS_NCONV_RST  = 16'h0000;
    localparam logic [15:0] ADS_BUFLEN_RST = 16'h0000;
    localparam logic [2:0]  ADS_TERM_RST   = 3'h0;
    localparam logic [2:0]  ADS_IRQ_RST    = 3'h0;

    typedef enum logic [1:0] {
        ADS_OFF,
        ADS_IDLE,
        ADS_BUSY,
        ADS_STOPPED
    } ads_state_e;
endpackage

// File: hw/ads_reg_if.sv
// interface: register strobes between the bus slave and the status core
`timescale 1ns/100ps
`default_nettype none
interface ads_reg_if;
    logic        rd_stb;
    logic        wr_stb;
    logic [4:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  be;

    modport slave (output rd_stb, output wr_stb, output addr, output wdata, output be);
    modport core  (input rd_stb, input wr_stb, input addr, input wdata, input be);
endinterface
`default_nettype wire

// File: hw/ads_avs_slave.sv
// module: avalon-mm handshake, one wait cycle per access
`timescale 1ns/100ps
`default_nettype none
module ads_avs_slave (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // avalon side
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic             avs_waitrequest,
    // core side
    ads_reg_if.slave         rif
);
    logic ack_reg;
    logic ack_next;

    // ack rises one cycle after the request so read data can be registered first
    always_comb begin
        ack_next = (avs_read | avs_write) & ~ack_reg;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= ack_next;
        end
    end

    // rd_stb loads read data; wr_stb commits at the completing edge only
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign rif.rd_stb      = avs_read & ~ack_reg;
    assign rif.wr_stb      = avs_write & ack_reg;
    assign rif.addr        = avs_address;
    assign rif.wdata       = avs_writedata;
    assign rif.be          = avs_byteenable;
endmodule
`default_nettype wire

// File: hw/ads_irq.sv
// module: sticky interrupt status with clear and enable
`timescale 1ns/100ps
`default_nettype none
module ads_irq
    import ads_pkg::*;
(
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    // events and software controls
    input  wire logic [ADS_IRQ_N-1:0] evt,
    input  wire logic [ADS_IRQ_N-1:0] clr,
    input  wire logic [ADS_IRQ_N-1:0] en,
    // results
    output logic      [ADS_IRQ_N-1:0] stat,
    output logic                      irq
);
    logic [ADS_IRQ_N-1:0] stat_reg;
    logic [ADS_IRQ_N-1:0] stat_next;

    // a set in the clearing cycle wins so no event is lost
    always_comb begin
        stat_next = (stat_reg & ~clr) | evt;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stat_reg <= ADS_IRQ_RST;
        end else begin
            stat_reg <= stat_next;
        end
    end

    assign stat = stat_reg;
    assign irq  = |(stat_reg & en);
endmodule
`default_nettype wire

// File: hw/ads_dma_status.sv
// module: transfer engine status core of the sequencer with register file
// What this block does
// - term cause cleared on new buffer, set on end
// - input unit error sets buffer abort bit
// - normal mode count reached sets block end
// - frame mode: count, or with a zero count the next trigger, ends
// - buffer exhausted sets buffer end, needs new buffer
// - master or target abort sets bus error
// - bus error stops engine, cleared by disable
// - read-only busy flag while transferring
// - read-only idle flag, cleared when disabled
// - nonzero length write while idle starts a transfer
// - queue overflow stops input unit, aborts buffer
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module ads_dma_status
    import ads_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // interrupt
    output logic             irq,
    // input unit side
    input  wire logic        iu_push,
    input  wire logic        queue_full,
    input  wire logic        iu_error,
    input  wire logic        frame_trigger,
    output logic             iu_halt,
    // host bus side, one word per request
    input  wire logic        sample_avail,
    output logic             xfer_req,
    input  wire logic        xfer_ack,
    input  wire logic        master_abort,
    input  wire logic        target_abort
);
    ads_reg_if rif ();

    ads_avs_slave u_slave (
        .clk_sys         (clk_sys),
        .rst_n           (rst_n),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_waitrequest (avs_waitrequest),
        .rif             (rif)
    );

    // merge write data into a register by byte lane
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // software registers
    logic [2:0]           ctrl_reg;
    logic [2:0]           ctrl_next;
    logic [ADS_CNT_W-1:0] nconv_reg;
    logic [ADS_CNT_W-1:0] nconv_next;
    logic [ADS_CNT_W-1:0] buflen_reg;
    logic [ADS_CNT_W-1:0] buflen_next;
    logic [ADS_IRQ_N-1:0] irq_en_reg;
    logic [ADS_IRQ_N-1:0] irq_en_next;
    logic [ADS_IRQ_N-1:0] irq_clr;
    logic [ADS_IRQ_N-1:0] irq_stat;
    logic [ADS_IRQ_N-1:0] irq_evt;
    logic                 buflen_wr;
    logic [31:0]          ctrl_w;
    logic [31:0]          nconv_w;
    logic [31:0]          buflen_w;
    logic [31:0]          irqen_w;
    logic [31:0]          clr_w;

    logic dma_en;
    logic iu_en;
    logic frame_mode;
    assign dma_en     = ctrl_reg[ADS_CTRL_DMA_EN_BIT];
    assign iu_en      = ctrl_reg[ADS_CTRL_IU_EN_BIT];
    assign frame_mode = ctrl_reg[ADS_CTRL_FRAME_BIT];

    // register writes; writes to the read-only status word and unmapped offsets fall away
    always_comb begin
        ctrl_w      = be_merge({29'h0, ctrl_reg}, rif.wdata, rif.be);
        nconv_w     = be_merge({16'h0, nconv_reg}, rif.wdata, rif.be);
        buflen_w    = be_merge({16'h0, buflen_reg}, rif.wdata, rif.be);
        irqen_w     = be_merge({29'h0, irq_en_reg}, rif.wdata, rif.be);
        clr_w       = be_merge(32'h0, rif.wdata, rif.be);
        ctrl_next   = ctrl_reg;
        nconv_next  = nconv_reg;
        buflen_next = buflen_reg;
        irq_en_next = irq_en_reg;
        irq_clr     = '0;
        buflen_wr   = 1'b0;
        if (rif.wr_stb) begin
            unique case (rif.addr)
                ADS_CTRL_OFS:    ctrl_next   = ctrl_w[2:0];
                ADS_NCONV_OFS:   nconv_next  = nconv_w[ADS_CNT_W-1:0];
                ADS_BUFLEN_OFS: begin
                    buflen_next = buflen_w[ADS_CNT_W-1:0];
                    buflen_wr   = 1'b1;
                end
                ADS_IRQ_CLR_OFS: irq_clr     = clr_w[ADS_IRQ_N-1:0];
                ADS_IRQ_EN_OFS:  irq_en_next = irqen_w[ADS_IRQ_N-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg   <= ADS_CTRL_RST;
            nconv_reg  <= ADS_NCONV_RST;
            buflen_reg <= ADS_BUFLEN_RST;
            irq_en_reg <= ADS_IRQ_RST;
        end else begin
            ctrl_reg   <= ctrl_next;
            nconv_reg  <= nconv_next;
            buflen_reg <= buflen_next;
            irq_en_reg <= irq_en_next;
        end
    end

    // input unit overflow: pushing into a full queue halts the unit until disabled
    logic ovf_reg;
    logic ovf_next;
    logic ovf_set;
    always_comb begin
        ovf_set  = iu_en & iu_push & queue_full & ~ovf_reg;
        ovf_next = iu_en & (ovf_reg | ovf_set);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ovf_reg <= 1'b0;
        end else begin
            ovf_reg <= ovf_next;
        end
    end

    assign iu_halt = ovf_reg | ~iu_en;

    // transfer engine state, counters, cause and error flag
    ads_state_e           state_reg;
    ads_state_e           state_next;
    logic [ADS_CNT_W-1:0] left_reg;
    logic [ADS_CNT_W-1:0] left_next;
    logic [ADS_CNT_W-1:0] done_reg;
    logic [ADS_CNT_W-1:0] done_next;
    logic [2:0]           term_reg;
    logic [2:0]           term_next;
    logic                 err_reg;
    logic                 err_next;
    logic                 bus_abort;
    logic                 unit_err;
    logic                 term_evt;
    logic                 count_hit;

    assign bus_abort = master_abort | target_abort;
    assign unit_err  = iu_error | ovf_set;
    // a zero count means continuous operation and never hits
    assign count_hit = (nconv_reg != '0) && (done_reg + 16'h0001 == nconv_reg);

    always_comb begin
        state_next = state_reg;
        left_next  = left_reg;
        done_next  = done_reg;
        term_next  = term_reg;
        err_next   = err_reg;
        term_evt   = 1'b0;
        if (buflen_wr) begin
            term_next = ADS_TERM_RST;
        end
        unique case (state_reg)
            ADS_OFF: begin
                if (dma_en) begin
                    state_next = ADS_IDLE;
                    done_next  = '0;
                end
            end
            ADS_IDLE: begin
                // starting outside idle is ignored, software must wait for idle
                if (buflen_wr && buflen_next != '0) begin
                    state_next = ADS_BUSY;
                    left_next  = buflen_next;
                end
            end
            ADS_BUSY: begin
                if (bus_abort) begin
                    err_next   = 1'b1;
                    state_next = ADS_STOPPED;
                end else if (unit_err) begin
                    term_next[ADS_TERM_ABORT] = 1'b1;
                    term_evt   = 1'b1;
                    done_next  = '0;
                    state_next = ADS_IDLE;
                end else if (frame_mode && nconv_reg == '0 && frame_trigger) begin
                    term_next[ADS_TERM_BLOCK] = 1'b1;
                    term_evt   = 1'b1;
                    state_next = ADS_IDLE;
                end else if (xfer_ack) begin
                    left_next = left_reg - 16'h0001;
                    done_next = done_reg + 16'h0001;
                    if (count_hit) begin
                        term_next[ADS_TERM_BLOCK] = 1'b1;
                        done_next = '0;
                    end
                    if (left_reg == 16'h0001) begin
                        term_next[ADS_TERM_BEND] = 1'b1;
                    end
                    if (count_hit || left_reg == 16'h0001) begin
                        term_evt   = 1'b1;
                        state_next = ADS_IDLE;
                    end
                end
            end
            ADS_STOPPED: ;
        endcase
        // disabling wins over every state transition and clears the error flag
        if (!dma_en) begin
            state_next = ADS_OFF;
            err_next   = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ADS_OFF;
            left_reg  <= '0;
            done_reg  <= '0;
            term_reg  <= ADS_TERM_RST;
            err_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            left_reg  <= left_next;
            done_reg  <= done_next;
            term_reg  <= term_next;
            err_reg   <= err_next;
        end
    end

    // one word is offered while busy and the queue has data
    assign xfer_req = (state_reg == ADS_BUSY) & sample_avail;

    // interrupt sources
    always_comb begin
        irq_evt                   = '0;
        irq_evt[ADS_IRQ_TERM_BIT] = term_evt;
        irq_evt[ADS_IRQ_ERR_BIT]  = (state_reg == ADS_BUSY) & bus_abort & dma_en;
        irq_evt[ADS_IRQ_OVF_BIT]  = ovf_set;
    end

    ads_irq u_irq (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .evt     (irq_evt),
        .clr     (irq_clr),
        .en      (irq_en_reg),
        .stat    (irq_stat),
        .irq     (irq)
    );

    // status word; every bit not listed reads zero
    logic [31:0] status_word;
    always_comb begin
        status_word                                 = 32'h0;
        status_word[ADS_ST_TERM_LSB +: 3]           = term_reg;
        status_word[ADS_ST_ERR_BIT]                 = err_reg;
        status_word[ADS_ST_BSY_BIT]                 = (state_reg == ADS_BUSY);
        status_word[ADS_ST_IDLE_BIT]                = (state_reg == ADS_IDLE);
        status_word[ADS_ST_OVF_BIT]                 = ovf_reg;
    end

    // read mux, registered in the wait cycle so data stand at the completing edge
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    always_comb begin
        rdata_next = rdata_reg;
        if (rif.rd_stb) begin
            unique case (rif.addr)
                ADS_CTRL_OFS:     rdata_next = {29'h0, ctrl_reg};
                ADS_NCONV_OFS:    rdata_next = {16'h0, nconv_reg};
                ADS_BUFLEN_OFS:   rdata_next = {16'h0, buflen_reg};
                ADS_STATUS_OFS:   rdata_next = status_word;
                ADS_IRQ_STAT_OFS: rdata_next = {29'h0, irq_stat};
                ADS_IRQ_EN_OFS:   rdata_next = {29'h0, irq_en_reg};
                default:          rdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 32'h0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign avs_readdata = rdata_reg;
endmodule
`default_nettype wire

// File: verif/ads_props.sv
// checker: port-level properties of the transfer status block
`timescale 1ns/100ps
`default_nettype none
module ads_props
    import ads_pkg::*;
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_n,
    // register bus
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        irq,
    // input unit
    input wire logic        iu_push,
    input wire logic        queue_full,
    input wire logic        iu_error,
    input wire logic        frame_trigger,
    input wire logic        iu_halt,
    // host bus
    input wire logic        sample_avail,
    input wire logic        xfer_req,
    input wire logic        xfer_ack,
    input wire logic        master_abort,
    input wire logic        target_abort
);
    // completed reads; readdata is only meaningful at these edges
    wire logic rd_done = avs_read && !avs_waitrequest;
    wire logic st_rd   = rd_done && (avs_address == ADS_STATUS_OFS);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    AST_WAIT_FIRST: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("no wait state on a new request");
    AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("more than one wait state");
    AST_STAT_RSV: assert property (st_rd |-> (avs_readdata & 32'hff88_ffef) == 32'h0)
        else $error("reserved status bit set");
    AST_BSY_IDLE: assert property (st_rd |-> !(avs_readdata[17] && avs_readdata[16]))
        else $error("busy and idle together");
    AST_UNMAP: assert property (rd_done && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_ERR_STOP: assert property (st_rd && avs_readdata[18] |-> !avs_readdata[17])
        else $error("engine busy with bus error set");
    AST_ABORT_STOP: assert property ((master_abort || target_abort) && xfer_req |=> !xfer_req [*4])
        else $error("engine kept running after bus abort");
    AST_HALT_OVF: assert property (iu_push && queue_full && !iu_halt |=> iu_halt [*2])
        else $error("overflow did not halt input unit");
    AST_RST_QUIET: assert property ($rose(rst_n) |-> !xfer_req && !irq)
        else $error("outputs active after reset");
    // main scenarios reached
    COV_ABORT: cover property (master_abort && xfer_req);
    COV_OVF: cover property (iu_push && queue_full && !iu_halt);
    COV_BEND: cover property (st_rd && avs_readdata[20]);
endmodule
`default_nettype wire

// File: verif/ads_host_model.sv
// partner: host bus target acking each word, promptly or slowly, or aborting
`timescale 1ns/100ps
`default_nettype none
module ads_host_model (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // bench controls: ack delay, abort kind (0 none, 1 master, 2 target)
    input  wire logic [3:0] dly,
    input  wire logic [1:0] abort_sel,
    // host bus side
    input  wire logic       xfer_req,
    output logic            xfer_ack,
    output logic            master_abort,
    output logic            target_abort
);
    logic [3:0] wait_reg;
    // one answer per request, then a gap cycle so two words never merge
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wait_reg <= 4'h0;
            {xfer_ack, master_abort, target_abort} <= 3'h0;
        end else if (xfer_req && !(xfer_ack || master_abort || target_abort) && wait_reg >= dly) begin
            wait_reg <= 4'h0;
            xfer_ack <= (abort_sel == 2'h0);
            master_abort <= (abort_sel == 2'h1);
            target_abort <= (abort_sel == 2'h2);
        end else begin
            wait_reg <= xfer_req ? wait_reg + 4'h1 : 4'h0;
            {xfer_ack, master_abort, target_abort} <= 3'h0;
        end
    end
endmodule
`default_nettype wire

// File: verif/ads_dma_status_tb_top.sv
// testbench: status core driven over avalon, host bus model on the far side
`timescale 1ns/100ps
`default_nettype none
module ads_dma_status_tb_top
    import ads_pkg::*;
;
    typedef struct packed {
        logic [2:0]  ctrl;
        logic [15:0] nconv;
        logic [15:0] blen;
        logic [2:0]  ev;
        logic [31:0] exp;
    } ads_row_s;
    logic        clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, irq;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0]  avs_byteenable, dly;
    logic        iu_push, queue_full, iu_error, frame_trigger, iu_halt;
    logic        sample_avail, xfer_req, xfer_ack, master_abort, target_abort;
    logic [1:0]  abort_sel;
    int          error_cnt, compares;
    // ev: 0 none, 1 unit error, 2 frame trigger, 3 overflow, 4 master abort, 5 target abort
    ads_row_s    rows [8] = '{
        '{3'h3, 16'h0, 16'h3, 3'h0, 32'h0011_0000},
        '{3'h3, 16'h2, 16'h5, 3'h0, 32'h0021_0000},
        '{3'h7, 16'h2, 16'h8, 3'h0, 32'h0021_0000},
        '{3'h7, 16'h0, 16'h8, 3'h2, 32'h0021_0000},
        '{3'h3, 16'h0, 16'h8, 3'h1, 32'h0041_0000},
        '{3'h3, 16'h0, 16'h8, 3'h3, 32'h0041_0010},
        '{3'h1, 16'h0, 16'h8, 3'h4, 32'h0004_0000},
        '{3'h1, 16'h0, 16'h8, 3'h5, 32'h0004_0000}};

    ads_dma_status ads_dma_status_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
        .iu_push(iu_push), .queue_full(queue_full), .iu_error(iu_error),
        .frame_trigger(frame_trigger), .iu_halt(iu_halt), .sample_avail(sample_avail),
        .xfer_req(xfer_req), .xfer_ack(xfer_ack), .master_abort(master_abort),
        .target_abort(target_abort));
    ads_host_model ads_host_model_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .dly(dly), .abort_sel(abort_sel), .xfer_req(xfer_req),
        .xfer_ack(xfer_ack), .master_abort(master_abort), .target_abort(target_abort));

    // 200 mhz system clock
    always #2.5 clk_sys = ~clk_sys;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one avalon access; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] rd);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk_sys);
        // no cycle limit here: only the watchdog ends a hung access
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk_sys);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask

    // poll status until busy drops, bounded
    task automatic wait_idle();
        for (int n = 0; n < 60; n++) begin
            bus(1'b0, ADS_STATUS_OFS, 32'h0, q);
            if (q[17] === 1'b0) return;
        end
        chk({31'h0, q[17]}, 32'h0);
    endtask

    // disable, configure, start one buffer, apply the row's event, check the end state
    task automatic run(input ads_row_s r, input logic slow);
        bus(1'b1, ADS_CTRL_OFS, 32'h0, q);
        bus(1'b0, ADS_STATUS_OFS, 32'h0, q);
        chk(q & 32'h0007_0000, 32'h0);
        bus(1'b1, ADS_CTRL_OFS, {29'h0, r.ctrl}, q);
        bus(1'b1, ADS_NCONV_OFS, {16'h0, r.nconv}, q);
        bus(1'b0, ADS_STATUS_OFS, 32'h0, q);
        chk(q & 32'h0007_0000, 32'h0001_0000);
        dly <= slow ? 4'h3 : 4'h0;
        abort_sel <= (r.ev > 3'h3) ? 2'(r.ev - 3'h3) : 2'h0;
        bus(1'b1, ADS_BUFLEN_OFS, {16'h0, r.blen}, q);
        bus(1'b0, ADS_STATUS_OFS, 32'h0, q);
        chk(q, 32'h0002_0000);
        iu_error <= (r.ev == 3'h1);
        frame_trigger <= (r.ev == 3'h2);
        iu_push <= (r.ev == 3'h3);
        queue_full <= (r.ev == 3'h3);
        sample_avail <= (r.ev == 3'h0) || (r.ev > 3'h3);
        @(posedge clk_sys);
        {iu_error, frame_trigger, iu_push, queue_full} <= 4'h0;
        wait_idle();
        sample_avail <= 1'b0;
        chk(q, r.exp);
        if (r.ev == 3'h3) chk({31'h0, iu_halt}, 32'h1);
    endtask

    task automatic test_done();
        if (error_cnt == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs a few hundred cycles
    initial begin
        #200000;
        error_cnt++;
        test_done();
    end

    initial begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        {avs_read, avs_write, iu_push, queue_full, iu_error, frame_trigger, sample_avail} = 7'h00;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        dly = 4'h0;
        abort_sel = 2'h0;
        error_cnt = 0;
        compares = 0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        bus(1'b0, ADS_STATUS_OFS, 32'h0, q);
        chk(q, 32'h0);
        chk({31'h0, iu_halt}, 32'h1);
        for (int i = 0; i < 8; i++) begin
            run(rows[i], i[0]);
        end
        // sticky events: termination, bus error, overflow all seen, none enabled yet
        bus(1'b0, ADS_IRQ_STAT_OFS, 32'h0, q);
        chk(q, 32'h7);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, ADS_IRQ_EN_OFS, 32'h2, q);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, ADS_IRQ_CLR_OFS, 32'h2, q);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, ADS_IRQ_STAT_OFS, 32'h0, q);
        bus(1'b0, ADS_IRQ_STAT_OFS, 32'h0, q);
        chk(q, 32'h5);
        bus(1'b1, ADS_STATUS_OFS, 32'hffff_ffff, q);
        // a length write outside idle stores the length and clears the cause, no restart
        bus(1'b1, ADS_BUFLEN_OFS, 32'h4, q);
        bus(1'b0, ADS_STATUS_OFS, 32'h0, q);
        chk(q, 32'h0004_0000);
        bus(1'b0, ADS_BUFLEN_OFS, 32'h0, q);
        chk(q, 32'h4);
        bus(1'b0, 5'h1c, 32'h0, q);
        chk(q, 32'h0);
        bus(1'b0, 5'h01, 32'h0, q);
        chk(q, 32'h0);
        // mid-run reset takes the stopped engine back to off, error cleared
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        bus(1'b0, ADS_STATUS_OFS, 32'h0, q);
        chk(q, 32'h0);
        test_done();
    end
endmodule

bind ads_dma_status ads_props ads_props_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .iu_push(iu_push), .queue_full(queue_full), .iu_error(iu_error),
    .frame_trigger(frame_trigger), .iu_halt(iu_halt), .sample_avail(sample_avail),
    .xfer_req(xfer_req), .xfer_ack(xfer_ack), .master_abort(master_abort),
    .target_abort(target_abort));
`default_nettype wire
